// *** pkg/bmon_pkg.sv ***
package bmon_pkg;

  // Configuration memory: shadow RAM bytes backed by EEPROM bytes
  localparam int CFG_BYTES = 76;
  localparam logic [7:0] CFG_LAST = 8'h4B;
  localparam logic [4:0] CFG_LAST_PAGE = 5'h12;
  // User EEPROM area, no shadow RAM
  localparam logic [7:0] USER_FIRST = 8'h50;
  localparam logic [7:0] USER_LAST = 8'h57;
  localparam int EE_PAGES = 22;
  localparam int PAGE_BYTES = 4;

  // Transient RAM area
  localparam logic [7:0] STAT_FIRST = 8'h80;
  localparam logic [7:0] STAT_LAST = 8'h84;
  localparam int STAT_IN_BYTES = 4;
  localparam logic [7:0] WR_FIRST = 8'h84;
  localparam logic [7:0] WR_LAST = 8'h89;
  localparam int N_OVR = 6;
  localparam logic [7:0] MEAS_FIRST = 8'h8E;
  localparam logic [7:0] MEAS_LAST = 8'hAB;
  localparam int MEAS_BYTES = 30;

  // memory_access_select register
  localparam logic [7:0] ACCESS_SEL = 8'h89;
  localparam int ACC_EE_BIT = 0;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] OVR_RESET = 8'h00;

  // overvoltage_threshold field in shadow RAM
  localparam int OV_LO_IDX = 0;
  localparam int OV_HI_IDX = 1;
  localparam int VOLT_W = 12;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_LOAD_CAP = 2'b01,
    ST_IDLE = 2'b10,
    ST_DONE = 2'b11
  } state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic page;
    logic [7:0] addr;
    logic [31:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic ready;
    logic ack;
    logic [7:0] rdata;
  } host_rsp_t;

endpackage

// *** rtl/ee_array.sv ***
`timescale 1ns/1ps
module ee_array #(
  parameter int DEPTH = 22,
  parameter int AW = 5,
  parameter int DW = 32
) (
  input wire logic core_clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // Cells ship cleared
  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = '0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule

// *** rtl/bmon_mem_access.sv ***
`timescale 1ns/1ps
// Function
// - Host writes in the RAM area land only at 84H to 89H.
// - A RAM write changes storage only when the write completes.
// - Status registers are readable at 80H to 83H.
// - Measurement results are readable at 8EH to ABH.
// - After reset the whole EEPROM configuration is copied to shadow.
// - Operation is governed by the shadow RAM values only.
// - EEPROM accesses never touch the shadow RAM.
// - EEPROM writes act only after the reload to shadow that follows reset.
// - A shadow threshold write changes fault detection at once.
// - The access code at 89H selects shadow RAM or EEPROM.
// - Shadow RAM bytes are writable one at a time.
// - Configuration memory spans 0H to 4BH, shadow plus EEPROM.
// - User area has no shadow, goes to EEPROM, reads zero when new.
module bmon_mem_access
  import bmon_pkg::*;
#(
  parameter int N_PAGES = EE_PAGES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire host_req_t host_req,
  output host_rsp_t host_rsp,
  input wire logic [STAT_IN_BYTES-1:0][7:0] status_in,
  input wire logic [MEAS_BYTES-1:0][7:0] meas_in,
  input wire logic [VOLT_W-1:0] cell_voltage_max,
  output logic [N_OVR-1:0][7:0] override_regs,
  output logic ov_fault,
  output logic cfg_loaded
);

  typedef struct packed {
    state_t state;
    logic [4:0] cnt;
    logic [CFG_BYTES-1:0][7:0] shadow;
    logic [N_OVR-1:0][7:0] ovr;
    host_req_t req;
    host_rsp_t rsp;
    logic ov_fault;
    logic loaded;
  } bmon_state_t;

  bmon_state_t st_q;
  bmon_state_t st_d;

  logic ee_we;
  logic [4:0] ee_addr;
  logic [31:0] ee_rdata;
  logic ee_sel;
  logic in_cfg;
  logic in_user;
  logic [7:0] ee_byte;
  logic [VOLT_W-1:0] ov_level;

  ee_array #(
    .DEPTH(N_PAGES),
    .AW(5),
    .DW(32)
  ) u_ee (
    .core_clk(core_clk),
    .ce(ce),
    .we(ee_we),
    .addr(ee_addr),
    .wdata(st_q.req.wdata),
    .rdata(ee_rdata)
  );

  always_comb begin
    ee_sel = st_q.ovr[ACCESS_SEL - WR_FIRST][ACC_EE_BIT];
    in_cfg = st_q.req.addr <= CFG_LAST;
    in_user = (st_q.req.addr >= USER_FIRST) && (st_q.req.addr <= USER_LAST);
    ee_byte = ee_rdata[8*st_q.req.addr[1:0] +: 8];
    ov_level = {st_q.shadow[OV_HI_IDX][3:0], st_q.shadow[OV_LO_IDX]};
    // Word address: load walk, committed request, or incoming request
    if (st_q.state == ST_LOAD) begin
      ee_addr = st_q.cnt;
    end else if (st_q.state == ST_DONE) begin
      ee_addr = st_q.req.addr[6:2];
    end else begin
      ee_addr = host_req.addr[6:2];
    end
    // Whole aligned page only, in EEPROM mode or the user area
    ee_we = (st_q.state == ST_DONE) && st_q.req.wr && st_q.req.page
      && (st_q.req.addr[1:0] == 2'b00)
      && ((in_cfg && ee_sel) || in_user);
  end

  always_comb begin
    st_d = st_q;
    st_d.rsp.ack = 1'b0;
    // Fault level follows live shadow contents
    st_d.ov_fault = st_q.loaded
      && (cell_voltage_max > ov_level);
    case (st_q.state)
      ST_LOAD: begin
        st_d.state = ST_LOAD_CAP;
      end
      ST_LOAD_CAP: begin
        for (int b = 0; b < PAGE_BYTES; b++) begin
          if (32'(st_q.cnt) * PAGE_BYTES + b < CFG_BYTES) begin
            st_d.shadow[7'(st_q.cnt * PAGE_BYTES + b)] =
              ee_rdata[8*b +: 8];
          end
        end
        if (st_q.cnt == CFG_LAST_PAGE) begin
          st_d.state = ST_IDLE;
          st_d.loaded = 1'b1;
          st_d.rsp.ready = 1'b1;
        end else begin
          st_d.cnt = st_q.cnt + 5'd1;
          st_d.state = ST_LOAD;
        end
      end
      ST_IDLE: begin
        if (host_req.rd || host_req.wr) begin
          st_d.req = host_req;
          st_d.rsp.ready = 1'b0;
          st_d.state = ST_DONE;
        end
      end
      ST_DONE: begin
        st_d.rsp.rdata = 8'h00;
        if (in_cfg && !ee_sel) begin
          st_d.rsp.rdata = st_q.shadow[st_q.req.addr[6:0]];
          if (st_q.req.wr && !st_q.req.page) begin
            st_d.shadow[st_q.req.addr[6:0]] =
              st_q.req.wdata[7:0];
          end
        end else if (in_cfg || in_user) begin
          st_d.rsp.rdata = ee_byte;
        end else if (st_q.req.addr >= WR_FIRST
          && st_q.req.addr <= WR_LAST) begin
          st_d.rsp.rdata = st_q.ovr[st_q.req.addr - WR_FIRST];
          if (st_q.req.wr && !st_q.req.page) begin
            st_d.ovr[st_q.req.addr - WR_FIRST] =
              st_q.req.wdata[7:0];
          end
        end else if (st_q.req.addr >= STAT_FIRST
          && st_q.req.addr < STAT_LAST) begin
          st_d.rsp.rdata =
            status_in[st_q.req.addr - STAT_FIRST];
        end else if (st_q.req.addr >= MEAS_FIRST
          && st_q.req.addr <= MEAS_LAST) begin
          st_d.rsp.rdata =
            meas_in[st_q.req.addr - MEAS_FIRST];
        end
        st_d.rsp.ack = 1'b1;
        st_d.rsp.ready = 1'b1;
        st_d.state = ST_IDLE;
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_q.state <= ST_LOAD;
      st_q.cnt <= 5'd0;
      st_q.shadow <= '0;
      st_q.ovr <= {ACC_RESET, {(N_OVR-1){OVR_RESET}}};
      st_q.req <= '0;
      st_q.rsp <= '0;
      st_q.ov_fault <= 1'b0;
      st_q.loaded <= 1'b0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign host_rsp = st_q.rsp;
  assign override_regs = st_q.ovr;
  assign ov_fault = st_q.ov_fault;
  assign cfg_loaded = st_q.loaded;

endmodule

// *** tb/bmon_mem_access_sva.sv ***
`timescale 1ns/1ps
module bmon_mem_access_sva
  import bmon_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic ce,
  input wire host_req_t host_req,
  input wire host_rsp_t host_rsp,
  input wire logic [STAT_IN_BYTES-1:0][7:0] status_in,
  input wire logic [N_OVR-1:0][7:0] override_regs,
  input wire logic ov_fault,
  input wire logic cfg_loaded
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic tk, wok;
  assign tk = ce && host_rsp.ready && (host_req.rd || host_req.wr);
  assign wok = host_req.addr inside {[WR_FIRST:WR_LAST]};
  sequence s_bw; tk && host_req.wr && !host_req.page; endsequence
  sequence s_ans; !host_rsp.ready ##1 (host_rsp.ack && host_rsp.ready);
  endsequence
  sequence s_load; !cfg_loaded[*8] ##[25:35] (cfg_loaded && host_rsp.ready);
  endsequence
  property p_ans; tk |=> s_ans; endproperty
  property p_land;
    s_bw ##0 wok |-> ##2 override_regs[$past(host_req.addr, 2) - WR_FIRST]
      == $past(host_req.wdata[7:0], 2);
  endproperty
  property p_ro; s_bw ##0 !wok |=> $stable(override_regs)[*2]; endproperty
  property p_cause;
    $changed(override_regs) |-> $past(tk && host_req.wr, 2);
  endproperty
  property p_stat;
    tk && host_req.rd && host_req.addr inside {[STAT_FIRST:8'h83]} |-> ##2
      host_rsp.rdata == $past(status_in[host_req.addr[1:0]], 2);
  endproperty
  property p_load; $fell(reset) |-> s_load; endproperty
  property p_gate; !cfg_loaded |-> !host_rsp.ready && !ov_fault; endproperty
  property p_keep; cfg_loaded |=> cfg_loaded; endproperty
  a_ans: assert property (p_ans) else $error("bad answer");
  a_land: assert property (p_land) else $error("lost write");
  a_ro: assert property (p_ro) else $error("ro changed");
  a_cause: assert property (p_cause) else $error("stray change");
  a_stat: assert property (p_stat) else $error("bad status");
  a_load: assert property (p_load) else $error("no load");
  a_gate: assert property (p_gate) else $error("early run");
  a_keep: assert property (p_keep) else $error("load lost");
endmodule
bind bmon_mem_access bmon_mem_access_sva sva (.*);

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model
  import bmon_pkg::*;
(
  input wire logic core_clk,
  input wire host_rsp_t host_rsp,
  output host_req_t host_req
);
  initial host_req = '0;
  // Hold until taken, then scramble idle lines
  task automatic xfer(input host_req_t r, output logic ok);
    int n;
    n = 0;
    @(negedge core_clk);
    host_req = r;
    do begin
      @(posedge core_clk);
      n++;
    end while (host_rsp.ready !== 1'b1 && n < 60);
    ok = host_rsp.ready;
    @(negedge core_clk);
    host_req = {2'b00, ~r[40:0]};
  endtask
endmodule

// *** tb/test_bmon_mem_access.sv ***
`timescale 1ns/1ps
`define CMP(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, e); end end
module test_bmon_mem_access;
  import bmon_pkg::*;
  logic core_clk = 0, reset = 1, ce = 1;
  host_req_t host_req;
  host_rsp_t host_rsp;
  logic [STAT_IN_BYTES-1:0][7:0] status_in;
  logic [MEAS_BYTES-1:0][7:0] meas_in;
  logic [VOLT_W-1:0] cell_voltage_max = '0;
  logic [N_OVR-1:0][7:0] override_regs;
  logic ov_fault, cfg_loaded;
  int failures = 0, checks = 0;
  logic [8:0] q[$];
  logic [8:0] e;
  always #10 core_clk = ~core_clk;
  bmon_mem_access uut (.core_clk, .reset, .ce, .host_req, .host_rsp,
    .status_in, .meas_in, .cell_voltage_max, .override_regs, .ov_fault,
    .cfg_loaded);
  host_model host (.core_clk, .host_rsp, .host_req);
  always @(negedge core_clk) begin
    if (host_rsp.ack === 1'b1) begin
      e = q.pop_front();
      if (e[8]) `CMP(host_rsp.rdata, e[7:0])
    end
  end
  task automatic stop_test();
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic acc(input logic w, p, input logic [7:0] a,
                     input logic [31:0] d, input logic [8:0] x);
    logic ok;
    q.push_back(x);
    host.xfer({!w, w, p, a, d}, ok);
    if (ok !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic rd(input logic [7:0] a, x);
    acc(1'b0, 1'b0, a, 32'h0, {1'b1, x});
  endtask
  task automatic wr(input logic p, input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, p, a, d, 9'h000);
  endtask
  task automatic boot();
    int n;
    n = 0;
    reset = 1;
    repeat (10) @(negedge core_clk);
    reset = 0;
    while (cfg_loaded !== 1'b1 && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    `CMP(cfg_loaded, 1'b1)
    if (cfg_loaded !== 1'b1) stop_test();
  endtask
  initial begin
    logic [31:0] pg;
    status_in = $urandom(52);
    foreach (meas_in[i]) meas_in[i] = 8'($urandom);
    boot();
    for (int i = 0; i < 10; i++) begin
      pg = $urandom;
      wr(1'b0, STAT_FIRST + 8'(i), pg);
      rd(STAT_FIRST + 8'(i), i < 4 ? status_in[i[1:0]] : pg[7:0]);
    end
    rd(MEAS_FIRST, meas_in[0]);
    rd(MEAS_LAST, meas_in[MEAS_BYTES-1]);
    wr(1'b0, ACCESS_SEL, 32'h0);
    wr(1'b0, 8'h00, 32'h0);
    wr(1'b0, 8'h01, 32'h4);
    cell_voltage_max = 12'h401;
    repeat (3) @(negedge core_clk);
    `CMP(ov_fault, 1'b1)
    wr(1'b0, ACCESS_SEL, 32'h1);
    @(negedge core_clk);
    `CMP(override_regs[N_OVR-1], 8'h01)
    wr(1'b1, 8'h00, 32'h7E5A0FFF);
    wr(1'b0, 8'h01, 32'h0);
    rd(8'h01, 8'h0F);
    rd(8'h03, 8'h7E);
    rd(USER_FIRST, 8'h00);
    wr(1'b1, USER_FIRST, pg);
    rd(8'h53, pg[31:24]);
    wr(1'b0, ACCESS_SEL, 32'h0);
    rd(8'h00, 8'h00);
    `CMP(ov_fault, 1'b1)
    repeat (2) @(negedge core_clk);
    boot();
    rd(8'h00, 8'hFF);
    repeat (3) @(negedge core_clk);
    `CMP(ov_fault, 1'b0)
    repeat (4) @(negedge core_clk);
    stop_test();
  end
endmodule
